/* File: core/gph_cmd_handler.sv */
// command handler for global parameter, user variable and homing commands
//
// Overview of operation
// [R1] Code 9 writes the 32-bit value into the parameter at type and bank.
// [R2] Bank 0 is module settings, 2 user variables, 3 interrupt setup.
// [R3] A write into bank 0 is also committed to nonvolatile memory by itself.
// [R4] A parameter write is answered with status 100 and a meaningless value.
// [R5] Code 10 copies the addressed parameter into the accumulator.
// [R6] The read is answered with status 100 and the parameter in the value.
// [R7] Code 11 on bank 2 saves the user variable into nonvolatile memory.
// [R8] After reset every user variable is reloaded from its saved copy.
// [R9] Code 12 on bank 2 reloads the user variable from its saved copy.
// [R10] Save and restore are answered with status 100 and value zero.
// [R11] Code 13 starts (0), stops (1) or queries (2) homing of the motor axis.
// [R12] The homing query answers zero when idle, nonzero while searching.
// [R13] Homing start and stop answer status 100 and a meaningless value.
// [R14] A frame is address, code, type, bank, value MSB first, checksum.
// [R15] The checksum is the modulo-256 sum of the eight bytes before it.
`timescale 1ns/1ps
module gph_cmd_handler
    import gph_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    output logic             reply_valid_ff,
    output logic [7:0]       reply_status_ff,
    output logic [7:0]       reply_instr_ff,
    output logic [31:0]      reply_value_ff,
    output logic             par_wr_ff,
    output logic             par_rd_ff,
    output logic [1:0]       par_bank_ff,
    output logic [7:0]       par_index_ff,
    output logic [31:0]      par_wdata_ff,
    input  wire logic        par_ack,
    input  wire logic [31:0] par_rdata,
    output logic             nvm_save_ff,
    output logic             nvm_load_ff,
    output logic [1:0]       nvm_bank_ff,
    output logic [7:0]       nvm_index_ff,
    input  wire logic        nvm_done,
    output logic [31:0]      accum_ff,
    output logic [5:0]       home_start_ff,
    output logic [5:0]       home_stop_ff,
    input  wire logic [5:0]  home_busy
);

    gph_state_t      state_ff, nxt_state;
    logic [3:0]      cnt_ff, nxt_cnt;
    logic [7:0]      sum_ff, nxt_sum;
    logic [7:0]      op_ff, nxt_op;
    logic [7:0]      typ_ff, nxt_typ;
    logic [7:0]      bank_ff, nxt_bank;
    logic [31:0]     val_ff, nxt_val;
    logic            csum_ok_ff, nxt_csum_ok;
    logic            need_par_ff, nxt_need_par;
    logic            need_nvm_ff, nxt_need_nvm;
    logic            nxt_reply_valid;
    logic [7:0]      nxt_reply_status;
    logic [7:0]      nxt_reply_instr;
    logic [31:0]     nxt_reply_value;
    logic            nxt_par_wr, nxt_par_rd;
    logic [1:0]      nxt_par_bank;
    logic [7:0]      nxt_par_index;
    logic [31:0]     nxt_par_wdata;
    logic            nxt_nvm_save, nxt_nvm_load;
    logic [1:0]      nxt_nvm_bank;
    logic [7:0]      nxt_nvm_index;
    logic [31:0]     nxt_accum;
    logic [5:0]      nxt_home_start, nxt_home_stop;
    logic [7:0]      boot_idx_ff, nxt_boot_idx;
    logic            bank_legal;
    logic [5:0]      axis_onehot;

    // bank legality and axis decode
    always_comb begin
        bank_legal = (bank_ff == BANK_GLOBAL) || (bank_ff == BANK_USER)
                     || (bank_ff == BANK_IRQ);                  // [R2]
        axis_onehot = 6'h00;
        if (bank_ff < NUM_AXES) begin
            axis_onehot = 6'h01 << bank_ff[2:0];
        end
    end

    // frame receive, execute and reply sequencing
    always_comb begin
        nxt_state        = state_ff;
        nxt_cnt          = cnt_ff;
        nxt_sum          = sum_ff;
        nxt_op           = op_ff;
        nxt_typ          = typ_ff;
        nxt_bank         = bank_ff;
        nxt_val          = val_ff;
        nxt_csum_ok      = csum_ok_ff;
        nxt_need_par     = need_par_ff;
        nxt_need_nvm     = need_nvm_ff;
        nxt_reply_valid  = 1'b0;
        nxt_reply_status = reply_status_ff;
        nxt_reply_instr  = reply_instr_ff;
        nxt_reply_value  = reply_value_ff;
        nxt_par_wr       = 1'b0;
        nxt_par_rd       = 1'b0;
        nxt_par_bank     = par_bank_ff;
        nxt_par_index    = par_index_ff;
        nxt_par_wdata    = par_wdata_ff;
        nxt_nvm_save     = 1'b0;
        nxt_nvm_load     = 1'b0;
        nxt_nvm_bank     = nvm_bank_ff;
        nxt_nvm_index    = nvm_index_ff;
        nxt_accum        = accum_ff;
        nxt_home_start   = 6'h00;
        nxt_home_stop    = 6'h00;
        nxt_boot_idx     = boot_idx_ff;
        case (state_ff)
            GPH_BOOT: begin
                // reload all user variables one by one
                if (!need_nvm_ff) begin
                    nxt_nvm_load  = 1'b1;                       // [R8]
                    nxt_nvm_bank  = BANK_USER[1:0];
                    nxt_nvm_index = boot_idx_ff;
                    nxt_need_nvm  = 1'b1;
                end else if (nvm_done) begin
                    nxt_need_nvm = 1'b0;
                    nxt_boot_idx = boot_idx_ff + 8'h01;
                    if (boot_idx_ff == UV_COUNT_MAX) begin
                        nxt_state = GPH_RECV;                   // [R8]
                    end
                end
            end
            GPH_RECV: begin
                if (rx_valid) begin
                    // byte order: addr, code, type, bank, value, sum
                    case (cnt_ff)                               // [R14]
                        4'h1: nxt_op = rx_byte;
                        4'h2: nxt_typ = rx_byte;
                        4'h3: nxt_bank = rx_byte;
                        4'h4, 4'h5, 4'h6, 4'h7:
                            nxt_val = {val_ff[23:0], rx_byte};
                        default: nxt_op = op_ff;
                    endcase
                    if (cnt_ff == FRAME_LAST) begin
                        nxt_csum_ok = (rx_byte == sum_ff);      // [R15]
                        nxt_cnt     = 4'h0;
                        nxt_sum     = 8'h00;
                        nxt_state   = GPH_EXEC;
                    end else begin
                        nxt_sum = sum_ff + rx_byte;             // [R15]
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
            end
            GPH_EXEC: begin
                nxt_reply_instr  = op_ff;
                nxt_reply_status = ST_OK;
                nxt_reply_value  = ZERO_WORD;
                nxt_need_par     = 1'b0;
                nxt_need_nvm     = 1'b0;
                nxt_par_bank     = bank_ff[1:0];
                nxt_par_index    = typ_ff;
                nxt_nvm_bank     = bank_ff[1:0];
                nxt_nvm_index    = typ_ff;
                nxt_state        = GPH_REPLY;
                if (!csum_ok_ff) begin
                    nxt_reply_status = ST_BAD_CSUM;
                end else begin
                    case (op_ff)
                        OP_SET_GP: begin
                            if (!bank_legal) begin
                                nxt_reply_status = ST_BAD_VALUE;
                            end else begin
                                nxt_par_wr    = 1'b1;           // [R1]
                                nxt_par_wdata = val_ff;
                                nxt_need_par  = 1'b1;
                                if (bank_ff == BANK_GLOBAL) begin
                                    nxt_need_nvm = 1'b1;
                                    nxt_nvm_save = 1'b1;        // [R3]
                                end
                                nxt_state     = GPH_WAIT;
                            end
                        end
                        OP_GET_GP: begin
                            if (!bank_legal) begin
                                nxt_reply_status = ST_BAD_VALUE;
                            end else begin
                                nxt_par_rd   = 1'b1;            // [R5]
                                nxt_need_par = 1'b1;
                                nxt_state    = GPH_WAIT;
                            end
                        end
                        OP_SAVE_UV, OP_RESTORE_UV: begin
                            if (bank_ff != BANK_USER) begin
                                nxt_reply_status = ST_BAD_VALUE;
                            end else begin
                                nxt_nvm_save = (op_ff == OP_SAVE_UV); // [R7]
                                nxt_nvm_load = (op_ff != OP_SAVE_UV); // [R9]
                                nxt_need_nvm = 1'b1;
                                nxt_state    = GPH_WAIT;
                            end
                        end
                        OP_HOMING: begin
                            if (axis_onehot == 6'h00) begin
                                nxt_reply_status = ST_BAD_VALUE;
                            end else if (typ_ff == HOME_START) begin
                                nxt_home_start = axis_onehot;   // [R11]
                            end else if (typ_ff == HOME_STOP) begin
                                nxt_home_stop = axis_onehot;    // [R11]
                            end else if (typ_ff == HOME_QUERY) begin
                                nxt_reply_value =
                                    {31'h0000_0000,
                                     |(home_busy & axis_onehot)}; // [R12]
                            end else begin
                                nxt_reply_status = ST_BAD_TYPE;
                            end
                        end
                        default: nxt_reply_status = ST_BAD_CMD;
                    endcase
                end
            end
            GPH_WAIT: begin
                // hold until each requested parameter bank or memory access has finished
                if (par_ack && need_par_ff) begin
                    nxt_need_par = 1'b0;
                    if (op_ff == OP_GET_GP) begin
                        nxt_accum       = par_rdata;            // [R5]
                        nxt_reply_value = par_rdata;            // [R6]
                    end
                end
                if (nvm_done && need_nvm_ff) begin
                    nxt_need_nvm = 1'b0;                        // [R3]
                end
                if (!nxt_need_par && !nxt_need_nvm) begin
                    nxt_state = GPH_REPLY;                      // [R4] [R10]
                end
            end
            GPH_REPLY: begin
                nxt_reply_valid = 1'b1;                         // [R13]
                nxt_state       = GPH_RECV;
            end
            default: nxt_state = GPH_RECV;
        endcase
    end

    // state and output registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff        <= GPH_BOOT;
            cnt_ff          <= 4'h0;
            sum_ff          <= 8'h00;
            op_ff           <= 8'h00;
            typ_ff          <= 8'h00;
            bank_ff         <= 8'h00;
            val_ff          <= 32'h0000_0000;
            csum_ok_ff      <= 1'b0;
            need_par_ff     <= 1'b0;
            need_nvm_ff     <= 1'b0;
            reply_valid_ff  <= 1'b0;
            reply_status_ff <= 8'h00;
            reply_instr_ff  <= 8'h00;
            reply_value_ff  <= 32'h0000_0000;
            par_wr_ff       <= 1'b0;
            par_rd_ff       <= 1'b0;
            par_bank_ff     <= 2'h0;
            par_index_ff    <= 8'h00;
            par_wdata_ff    <= 32'h0000_0000;
            nvm_save_ff     <= 1'b0;
            nvm_load_ff     <= 1'b0;
            nvm_bank_ff     <= 2'h0;
            nvm_index_ff    <= 8'h00;
            accum_ff        <= 32'h0000_0000;
            home_start_ff   <= 6'h00;
            home_stop_ff    <= 6'h00;
            boot_idx_ff     <= 8'h00;
        end else begin
            state_ff        <= nxt_state;
            cnt_ff          <= nxt_cnt;
            sum_ff          <= nxt_sum;
            op_ff           <= nxt_op;
            typ_ff          <= nxt_typ;
            bank_ff         <= nxt_bank;
            val_ff          <= nxt_val;
            csum_ok_ff      <= nxt_csum_ok;
            need_par_ff     <= nxt_need_par;
            need_nvm_ff     <= nxt_need_nvm;
            reply_valid_ff  <= nxt_reply_valid;
            reply_status_ff <= nxt_reply_status;
            reply_instr_ff  <= nxt_reply_instr;
            reply_value_ff  <= nxt_reply_value;
            par_wr_ff       <= nxt_par_wr;
            par_rd_ff       <= nxt_par_rd;
            par_bank_ff     <= nxt_par_bank;
            par_index_ff    <= nxt_par_index;
            par_wdata_ff    <= nxt_par_wdata;
            nvm_save_ff     <= nxt_nvm_save;
            nvm_load_ff     <= nxt_nvm_load;
            nvm_bank_ff     <= nxt_nvm_bank;
            nvm_index_ff    <= nxt_nvm_index;
            accum_ff        <= nxt_accum;
            home_start_ff   <= nxt_home_start;
            home_stop_ff    <= nxt_home_stop;
            boot_idx_ff     <= nxt_boot_idx;
        end
    end

endmodule

/* File: include/gph_pkg.sv */
// shared constants for the global parameter and homing command handler
package gph_pkg;
    localparam logic [7:0] OP_SET_GP     = 8'h09;
    localparam logic [7:0] OP_GET_GP     = 8'h0A;
    localparam logic [7:0] OP_SAVE_UV    = 8'h0B;
    localparam logic [7:0] OP_RESTORE_UV = 8'h0C;
    localparam logic [7:0] OP_HOMING     = 8'h0D;
    localparam logic [7:0] BANK_GLOBAL   = 8'h00;
    localparam logic [7:0] BANK_USER     = 8'h02;
    localparam logic [7:0] BANK_IRQ      = 8'h03;
    localparam logic [7:0] HOME_START    = 8'h00;
    localparam logic [7:0] HOME_STOP     = 8'h01;
    localparam logic [7:0] HOME_QUERY    = 8'h02;
    localparam logic [7:0] ST_OK         = 8'h64;
    localparam logic [7:0] ST_BAD_CSUM   = 8'h01;
    localparam logic [7:0] ST_BAD_CMD    = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE   = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE  = 8'h04;
    localparam logic [3:0] FRAME_LAST    = 4'h8;
    localparam logic [7:0] NUM_AXES      = 8'h06;
    localparam logic [7:0] NUM_UVARS     = 8'h00;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    localparam logic [7:0] UV_COUNT_MAX  = 8'hFF;
    typedef enum logic [2:0] {
        GPH_BOOT  = 3'b000,
        GPH_RECV  = 3'b001,
        GPH_EXEC  = 3'b010,
        GPH_WAIT  = 3'b011,
        GPH_REPLY = 3'b100
    } gph_state_t;
endpackage

/* File: tb/gph_cmd_handler_bench.sv */
// testbench for the command handler
`timescale 1ns/1ps
module gph_cmd_handler_bench;
    import gph_pkg::*;
    logic        core_clk, rst_n, rx_valid, reply_valid_ff, par_wr_ff;
    logic        par_rd_ff, par_ack, nvm_save_ff, nvm_load_ff, nvm_done;
    logic [7:0]  rx_byte, reply_status_ff, reply_instr_ff, par_index_ff;
    logic [7:0]  nvm_index_ff;
    logic [1:0]  par_bank_ff, nvm_bank_ff;
    logic [31:0] reply_value_ff, par_wdata_ff, par_rdata, accum_ff;
    logic [5:0]  home_start_ff, home_stop_ff, home_busy, hs, hp;
    logic [31:0] mem [4][256];
    logic [31:0] nvm [4][256];
    logic [41:0] last_wr;
    logic [7:0]  banks [3] = '{BANK_GLOBAL, BANK_USER, BANK_IRQ};
    logic        got_reply;
    int          seed = 32'hA9A3;
    int          mismatches, checked, n_wr, n_save, n_load;
    gph_cmd_handler dut (.core_clk, .rst_n, .rx_valid, .rx_byte,
        .reply_valid_ff, .reply_status_ff, .reply_instr_ff, .reply_value_ff,
        .par_wr_ff, .par_rd_ff, .par_bank_ff, .par_index_ff, .par_wdata_ff,
        .par_ack, .par_rdata, .nvm_save_ff, .nvm_load_ff, .nvm_bank_ff,
        .nvm_index_ff, .nvm_done, .accum_ff, .home_start_ff, .home_stop_ff,
        .home_busy);
    gph_host_model host (.core_clk, .rx_valid, .rx_byte);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic expect_eq(input logic [63:0] got, exp, input string msg);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // parameter bank, answers after a random stall
    always @(posedge core_clk) if (par_wr_ff || par_rd_ff) begin
        if (par_wr_ff) begin
            mem[par_bank_ff][par_index_ff] = par_wdata_ff;
            last_wr = {par_bank_ff, par_index_ff, par_wdata_ff};
            n_wr++;
        end
        repeat ($random(seed) & 3) @(posedge core_clk);
        #2 par_rdata = mem[par_bank_ff][par_index_ff];
        par_ack = 1'b1;
        @(posedge core_clk);
        #2 par_ack = 1'b0;
        par_rdata = ~par_rdata;
    end
    // nonvolatile memory model
    always @(posedge core_clk) if (nvm_save_ff || nvm_load_ff) begin
        if (nvm_save_ff) begin
            nvm[nvm_bank_ff][nvm_index_ff] = par_wr_ff ? par_wdata_ff
                : mem[nvm_bank_ff][nvm_index_ff];
            n_save++;
        end else begin
            expect_eq(nvm_bank_ff, 2'h2, "load bank");
            if (n_load < 256)
                expect_eq(nvm_index_ff, n_load[7:0], "boot index");
            mem[2][nvm_index_ff] = nvm[2][nvm_index_ff];
            n_load++;
        end
        repeat (2) @(posedge core_clk);
        #2 nvm_done = 1'b1;
        @(posedge core_clk);
        #2 nvm_done = 1'b0;
    end
    // reply and homing pulse capture
    always @(posedge core_clk) begin
        if (reply_valid_ff === 1'b1) got_reply <= 1'b1;
        hs <= hs | home_start_ff;
        hp <= hp | home_stop_ff;
    end
    task automatic cmd(input logic [7:0] op, typ, bnk, input logic [31:0] val,
            input logic bad, input logic [7:0] est, input logic [31:0] ev,
            input logic chkv);
        int t;
        got_reply = 1'b0;
        host.send({8'h01, op, typ, bnk, val}, bad);
        t = 0;
        while (!got_reply && t < 400) begin
            @(posedge core_clk);
            t++;
        end
        #2;
        expect_eq(got_reply, 1'b1, "no reply");
        expect_eq(reply_status_ff, est, "status");
        if (!bad) expect_eq(reply_instr_ff, op, "instr");
        if (chkv) expect_eq(reply_value_ff, ev, "value");
    endtask
    initial begin
        logic [7:0]  idx;
        logic [31:0] v;
        int          s0;
        int          t;
        {rst_n, par_ack, nvm_done, par_rdata, home_busy} = '0;
        for (int i = 0; i < 256; i++) nvm[2][i] = $random(seed);
        repeat (16) @(posedge core_clk);
        #2 rst_n = 1'b1;
        t = 0;
        while (n_load < 256 && t < 4000) begin
            @(posedge core_clk);
            t++;
        end
        repeat (8) @(posedge core_clk);
        #2 expect_eq(n_load, 256, "boot loads");
        cmd(OP_GET_GP, 8'h10, BANK_USER, 0, 0, ST_OK, nvm[2][16], 1);
        for (int b = 0; b < 3; b++) begin
            for (int k = 0; k < 3; k++) begin
                idx = (k == 0) ? 8'hFF : 8'($random(seed));
                v = $random(seed);
                s0 = n_save;
                cmd(OP_SET_GP, idx, banks[b], v, 0, ST_OK, 0, 0);
                expect_eq(last_wr, {banks[b][1:0], idx, v}, "write");
                expect_eq(n_save - s0, b == 0, "autosave");
                cmd(OP_GET_GP, idx, banks[b], ~v, 0, ST_OK, v, 1);
                expect_eq(accum_ff, v, "accum");
            end
        end
        idx = 8'($random(seed));
        v = $random(seed);
        cmd(OP_SET_GP, idx, BANK_USER, v, 0, ST_OK, 0, 0);
        cmd(OP_SAVE_UV, idx, BANK_USER, ~v, 0, ST_OK, 0, 1);
        expect_eq(nvm[2][idx], v, "saved copy");
        cmd(OP_SET_GP, idx, BANK_USER, ~v, 0, ST_OK, 0, 0);
        cmd(OP_RESTORE_UV, idx, BANK_USER, v, 0, ST_OK, 0, 1);
        cmd(OP_GET_GP, idx, BANK_USER, 0, 0, ST_OK, v, 1);
        for (int ax = 0; ax < 6; ax++) begin
            for (int ty = 0; ty < 3; ty++) begin
                home_busy = 6'($random(seed));
                hs = 6'h00;
                hp = 6'h00;
                cmd(OP_HOMING, ty[7:0], ax[7:0], $random(seed), 0, ST_OK,
                    {31'h0, home_busy[ax]}, ty == 2);
                expect_eq(hs, ty == 0 ? 6'h01 << ax : 6'h00, "start");
                expect_eq(hp, ty == 1 ? 6'h01 << ax : 6'h00, "stop");
            end
        end
        s0 = n_wr;
        cmd(OP_SET_GP, 8'h01, 8'h01, 1, 0, ST_BAD_VALUE, 0, 0);
        cmd(OP_SET_GP, 8'h01, BANK_GLOBAL, 1, 1, ST_BAD_CSUM, 0, 0);
        expect_eq(n_wr, s0, "refused write");
        cmd(OP_HOMING, 8'h03, 8'h00, 0, 0, ST_BAD_TYPE, 0, 0);
        cmd(OP_HOMING, HOME_START, NUM_AXES, 0, 0, ST_BAD_VALUE, 0, 0);
        stop_test;
    end
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        stop_test;
    end
endmodule
bind gph_cmd_handler gph_cmd_monitor u_mon (.core_clk, .rst_n,
    .reply_valid_ff, .reply_status_ff, .reply_value_ff, .par_wr_ff,
    .par_rd_ff, .par_bank_ff, .par_index_ff, .par_ack, .par_rdata,
    .nvm_save_ff, .nvm_load_ff, .nvm_bank_ff, .nvm_index_ff, .nvm_done,
    .accum_ff, .home_start_ff, .home_stop_ff);

/* File: tb/gph_cmd_monitor.sv */
// checker on the command handler ports
`timescale 1ns/1ps
module gph_cmd_monitor
    import gph_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        reply_valid_ff,
    input wire logic [7:0]  reply_status_ff,
    input wire logic [31:0] reply_value_ff,
    input wire logic        par_wr_ff,
    input wire logic        par_rd_ff,
    input wire logic [1:0]  par_bank_ff,
    input wire logic [7:0]  par_index_ff,
    input wire logic        par_ack,
    input wire logic [31:0] par_rdata,
    input wire logic        nvm_save_ff,
    input wire logic        nvm_load_ff,
    input wire logic [1:0]  nvm_bank_ff,
    input wire logic [7:0]  nvm_index_ff,
    input wire logic        nvm_done,
    input wire logic [31:0] accum_ff,
    input wire logic [5:0]  home_start_ff,
    input wire logic [5:0]  home_stop_ff
);
    logic rd_pend_ff;
    logic nxt_rd_pend;
    logic sv_pend_ff;
    logic nxt_sv_pend;
    // open read and lone save tracking
    always_comb begin
        nxt_rd_pend = par_rd_ff | (rd_pend_ff & ~par_ack);
        nxt_sv_pend = (nvm_save_ff & ~par_wr_ff) | (sv_pend_ff & ~nvm_done);
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'b0;
            sv_pend_ff <= 1'b0;
        end else begin
            rd_pend_ff <= nxt_rd_pend;
            sv_pend_ff <= nxt_sv_pend;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_reply_pulse; reply_valid_ff |=> !reply_valid_ff; endproperty
    // fields are loaded before the strobe and stay put for the eight cycles after it
    property p_reply_hold;
        reply_valid_ff |=> ($stable(reply_status_ff)
            && $stable(reply_value_ff)) [*8];
    endproperty
    property p_wr_save; par_wr_ff && par_bank_ff == 2'h0 |-> nvm_save_ff
        && nvm_bank_ff == 2'h0 && nvm_index_ff == par_index_ff; endproperty
    property p_wr_nosave;
        par_wr_ff && par_bank_ff != 2'h0 |-> !nvm_save_ff;
    endproperty
    property p_accum; par_ack && rd_pend_ff |=> accum_ff == $past(par_rdata)
        ##1 reply_valid_ff && reply_value_ff == accum_ff; endproperty
    property p_uv_reply; nvm_done && sv_pend_ff |-> ##2 reply_valid_ff
        && reply_value_ff == 32'h0 && reply_status_ff == ST_OK; endproperty
    property p_home; (home_start_ff | home_stop_ff) != 6'h00
        |-> $onehot(home_start_ff | home_stop_ff)
        ##1 (home_start_ff | home_stop_ff) == 6'h00; endproperty
    property p_load_bank;
        nvm_load_ff |-> nvm_bank_ff == 2'h2 && !nvm_save_ff;
    endproperty
    a_reply_pulse: assert property (p_reply_pulse)
        else $error("reply strobe longer than one cycle");
    a_reply_hold: assert property (p_reply_hold)
        else $error("reply fields moved right after strobe");
    a_wr_save: assert property (p_wr_save)
        else $error("bank 0 write not committed");
    a_wr_nosave: assert property (p_wr_nosave)
        else $error("save on non global bank write");
    a_accum: assert property (p_accum)
        else $error("read data not in accumulator and reply");
    a_uv_reply: assert property (p_uv_reply)
        else $error("save reply wrong");
    a_home: assert property (p_home)
        else $error("homing pulse not one hot single cycle");
    a_load_bank: assert property (p_load_bank)
        else $error("load outside user bank");
    c_read: cover property (par_ack && rd_pend_ff);
    c_save: cover property (nvm_done && sv_pend_ff);
    c_home: cover property (home_start_ff != 6'h00);
endmodule

/* File: tb/gph_host_model.sv */
// host model sending command frames byte by byte
`timescale 1ns/1ps
module gph_host_model (
    input  wire logic  core_clk,
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'hA5;
    end
    // eight body bytes back to back, then the checksum
    task automatic send(input logic [63:0] body, input logic bad);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            #2;
            if (i < 8) begin
                rx_byte = body[63-8*i -: 8];
                sum = sum + rx_byte;
            end else
                rx_byte = sum ^ {7'h00, bad};
            rx_valid = 1'b1;
        end
        @(posedge core_clk);
        #2;
        rx_valid = 1'b0;
        rx_byte  = ~rx_byte; // no stale byte after release
    endtask
endmodule
